// File: rsq_board_model.sv
// Board supervisor, strap resistors and free-running reference clocks around the sequencer
`timescale 1ns/1ps
module rsq_board_model
	import rsq_pkg::*;
(
	input wire logic clk,
	input wire logic hrst_oe,
	input wire logic [STRAP_W-1:0] strap_o,
	input wire logic [STRAP_W-1:0] strap_oe,
	output logic por_n,
	output logic hrst_wire,
	output logic prim_clk,
	output logic sync_clk,
	output logic host,
	output logic [STRAP_W-1:0] strap_wire
);
	logic hrst_pull = 1'h0;
	logic ref_clk;
	logic [STRAP_W-1:0] strap_res = '0;

	initial begin
		por_n = 1'h1;
		prim_clk = 1'h0;
		sync_clk = 1'h0;
		host = 1'h1;
	end
	// Offset keeps reference edges away from the sampling clock edges
	always begin
		#0.5;
		fork
			forever #10 prim_clk = ~prim_clk;
			forever #15 sync_clk = ~sync_clk;
		join
	end
	assign ref_clk = host ? prim_clk : sync_clk;
	// Pull-up wins unless some party pulls low
	assign hrst_wire = ~(hrst_oe | hrst_pull);
	assign strap_wire = (strap_oe & strap_o) | (~strap_oe & strap_res);

	// ----------------------------------------------------------------
	// Supervisor actions
	// ----------------------------------------------------------------
	task automatic power_on(input int n, input logic h, input logic [STRAP_W-1:0] s);
		@(posedge clk);
		host <= h;
		strap_res <= s;
		por_n <= 1'h0;
		repeat (n) @(posedge ref_clk);
		@(posedge clk);
		por_n <= 1'h1;
	endtask
	task automatic hard_reset(input int n);
		@(posedge clk);
		hrst_pull <= 1'h1;
		repeat (n) @(posedge ref_clk);
		@(posedge clk);
		hrst_pull <= 1'h0;
	endtask
	// Straps may change once hard reset has negated
	task automatic retarget(input logic [STRAP_W-1:0] s);
		@(posedge clk);
		strap_res <= s;
	endtask
endmodule

// File: rsq_pkg.sv
// Shared constants, strap layout, register map and helpers of the reset sequencer
package rsq_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int PLL_LOCK_US = 100;
	localparam int PLL_LOCK_CYC_DEF = (PLL_LOCK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STRAP_OFF_NS = 4;
	localparam int STRAP_OFF_CYC = (STRAP_OFF_NS / CLK_PERIOD_NS < 1) ? 1 :
		STRAP_OFF_NS / CLK_PERIOD_NS;
	localparam int TICK_W = 10;
	localparam int LOCK_W = 16;
	localparam logic [TICK_W-1:0] HRST_IN_MIN_TICKS = 10'h020;
	localparam logic [TICK_W-1:0] POR_MIN_TICKS = 10'h020;
	localparam logic [TICK_W-1:0] HRST_OUT_TICKS = 10'h200;
	localparam logic [TICK_W-1:0] NEG_GAP_TICKS = 10'h010;
	localparam logic [TICK_W-1:0] FUNC_DELAY_TICKS = 10'h001;
	localparam logic [TICK_W-1:0] CFG_SETUP_TICKS = 10'h004;
	localparam logic [TICK_W-1:0] TICK_MAX = 10'h3ff;

	// ----------------------------------------------------------------
	// Strap and sampled-input layout
	// ----------------------------------------------------------------
	localparam int STRAP_W = 6;
	localparam int SRC_LSB = 0;
	localparam int SRC_W = 4;
	localparam int DIV_BIT = 4;
	localparam int LBMUX_BIT = 5;
	localparam int IN_W = 8;
	localparam int IN_HOST_BIT = 6;
	localparam int IN_PLL_BIT = 7;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int AW = 12;
	localparam logic [AW-1:0] ADDR_CTRL = 12'h000;
	localparam logic [AW-1:0] ADDR_STATUS = 12'h004;
	localparam int CTRL_SWRST_BIT = 0;
	localparam int CTRL_TOCLR_BIT = 1;
	localparam int CTRL_FUNC_LSB = 8;
	localparam int STS_STATE_LSB = 0;
	localparam int STS_STATE_W = 3;
	localparam int STS_LOCK_BIT = 4;
	localparam int STS_TIMEOUT_BIT = 5;
	localparam int STS_HOST_BIT = 6;
	localparam int STS_SYSRST_BIT = 7;
	localparam int STS_STRAP_LSB = 8;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		ST_POR, ST_HRST_DRIVE, ST_HRST_WAIT, ST_FUNC_WAIT, ST_PLL_WAIT, ST_RUN
	} rsq_state_t;

	// Level changes only once second and third synchroniser stages agree
	function automatic logic rsq_filt(input logic lvl, input logic s2, input logic s3);
		return (s2 == s3) ? s2 : lvl;
	endfunction

	function automatic logic [TICK_W-1:0] rsq_sat_inc(input logic [TICK_W-1:0] v);
		return (v == TICK_MAX) ? v : v + 10'h001;
	endfunction

endpackage

// File: rsq_qualify.sv
// Synchronises a reset pin and qualifies its assertion by a minimum tick count
`timescale 1ns/1ps
module rsq_qualify
	import rsq_pkg::*;
#(
	parameter logic [TICK_W-1:0] MIN_TICKS = HRST_IN_MIN_TICKS
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic pin_n,
	input wire logic tick,
	output logic level_low,
	output logic qual
);

	typedef struct packed {
		logic [2:0] sy;
		logic low;
		logic [TICK_W-1:0] cnt;
		logic qual;
	} rsq_qual_st_t;

	rsq_qual_st_t s;
	rsq_qual_st_t n;

	always_comb begin
		n = s;
		n.sy = {s.sy[1:0], pin_n};
		n.low = ~rsq_filt(~s.low, s.sy[1], s.sy[2]); // R15
		if (!n.low) begin
			n.cnt = '0;
			n.qual = 1'b0;
		end else begin
			if (tick) begin
				n.cnt = rsq_sat_inc(s.cnt);
			end
			if (n.cnt > MIN_TICKS) begin
				n.qual = 1'b1; // R15
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			// Pin idles high, so the synchroniser starts high to avoid a false low
			s <= '{sy: '1, default: '0};
		end else begin
			s <= n;
		end
	end

	assign level_low = s.low;
	assign qual = s.qual;

	property p_qual_len;
		@(posedge clk) disable iff (!rstn)
		$rose(s.qual) |-> (s.cnt > MIN_TICKS) && s.low;
	endproperty
	a_qual_len: assert property (p_qual_len) else $error("reset qualified too early"); // R15

	property p_qual_drop;
		@(posedge clk) disable iff (!rstn)
		!s.low |-> !s.qual;
	endproperty
	a_qual_drop: assert property (p_qual_drop) else $error("qualified while pin high"); // R15

endmodule

// File: rsq_reset_init_sequencer.sv
// Reset-initialisation sequencer with strap capture and AXI4-Lite registers
// Function
// (R1) Outside party holds hard reset input low at least 32 sync-clock periods.
// (R2) Host mode: power-on reset held low 32 stable primary-clock periods.
// (R3) Agent mode: power-on reset held low 32 stable PCI-clock periods.
// (R4) Hard reset output low at least 512 sync periods; 16 between negations.
// (R5) Straps set up 4 reference periods before power-on reset negation.
// (R6) Straps stay stable until hard reset negates; zero hold allowed.
// (R7) Stop driving strap pins within 4 ns of hard reset assertion.
// (R8) Drive strap-shared outputs only 1 sync period after hard reset negation.
// (R9) Allow 100 us PLL lock time before using derived clocks.
// (R10) Host mode sync period derived from primary clock via divider strap.
// (R11) Straps: four-bit reset source, input clock divider, local bus mux.
// (R12) Primary-clock timing only in host mode; sync clock in agent mode.
// (R13) Hard reset pin is open drain: device only pulls low.
// (R14) Straps captured at power-on reset negation, kept until next one.
// (R15) Reset inputs synchronised before their assertion length is counted.
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module rsq_reset_init_sequencer
	import rsq_pkg::*;
#(
	parameter int PLL_LOCK_CYCLES = PLL_LOCK_CYC_DEF
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic POWER_ON_RESET_N,
	input wire logic HARD_RESET_N_I,
	output logic HARD_RESET_N_O,
	output logic HARD_RESET_N_OE,
	input wire logic PRIMARY_CLOCK_IN,
	input wire logic PCI_SYNC_CLOCK_IN,
	input wire logic PCI_HOST_MODE,
	input wire logic PLL_LOCKED,
	input wire logic [STRAP_W-1:0] CFG_STRAP_I,
	output logic [STRAP_W-1:0] CFG_STRAP_O,
	output logic [STRAP_W-1:0] CFG_STRAP_OE,
	output logic SYSTEM_RESET_N,
	input wire logic [AW-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [AW-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		rsq_state_t state;
		logic armed;
		logic [TICK_W-1:0] tcnt;
		logic [TICK_W-1:0] gap;
		logic [LOCK_W-1:0] lock;
		logic [IN_W-1:0] sy0;
		logic [IN_W-1:0] sy1;
		logic [IN_W-1:0] sy2;
		logic [IN_W-1:0] lvl;
		logic [STRAP_W-1:0] straps;
		logic host;
		logic timeout;
		logic hr_o;
		logic hr_oe;
		logic strap_oe;
		logic sysrst_n;
		logic [STRAP_W-1:0] func_out;
		logic awrdy;
		logic wrdy;
		logic aw_hold;
		logic w_hold;
		logic [AW-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arrdy;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} rsq_main_st_t;

	localparam rsq_main_st_t MAIN_RST = '{state: ST_POR, hr_oe: 1'b1, awrdy: 1'b1,
		wrdy: 1'b1, arrdy: 1'b1, default: '0};
	localparam logic [LOCK_W-1:0] LOCK_TARGET = LOCK_W'(PLL_LOCK_CYCLES);

	rsq_main_st_t s;
	rsq_main_st_t n;
	rsq_tick_if tk();
	logic host_live;
	logic div_live;
	logic por_low;
	logic por_qual;
	logic hr_low;
	logic hr_qual;

	// ----------------------------------------------------------------
	// Tick generation and reset qualification
	// ----------------------------------------------------------------
	// Before capture the live strap levels steer the clock choice
	assign host_live = (s.state == ST_POR) ? s.lvl[IN_HOST_BIT] : s.host;
	assign div_live = (s.state == ST_POR) ? s.lvl[DIV_BIT] : s.straps[DIV_BIT];

	rsq_ticker u_ticker (
		.clk(CLK),
		.rstn(RESETN),
		.prim_pin(PRIMARY_CLOCK_IN),
		.sync_pin(PCI_SYNC_CLOCK_IN),
		.host_mode(host_live),
		.div_strap(div_live),
		.tk(tk.src)
	);

	// Power-on reset counted in primary or PCI clock periods by mode
	rsq_qualify #(.MIN_TICKS(POR_MIN_TICKS)) u_por_q ( // R2 R3
		.clk(CLK),
		.rstn(RESETN),
		.pin_n(POWER_ON_RESET_N),
		.tick(tk.ref_tick),
		.level_low(por_low),
		.qual(por_qual)
	);

	rsq_qualify #(.MIN_TICKS(HRST_IN_MIN_TICKS)) u_hr_q ( // R1
		.clk(CLK),
		.rstn(RESETN),
		.pin_n(HARD_RESET_N_I),
		.tick(tk.sync_tick),
		.level_low(hr_low),
		.qual(hr_qual)
	);

	// ----------------------------------------------------------------
	// Sequencer and register slave
	// ----------------------------------------------------------------
	always_comb begin
		n = s;
		n.sy0 = {PLL_LOCKED, PCI_HOST_MODE, CFG_STRAP_I};
		n.sy1 = s.sy0;
		n.sy2 = s.sy1;
		for (int i = 0; i < IN_W; i++) begin
			n.lvl[i] = rsq_filt(s.lvl[i], s.sy1[i], s.sy2[i]);
		end
		n.hr_o = 1'b0; // R13
		if (tk.sync_tick) begin
			n.gap = rsq_sat_inc(s.gap);
		end
		case (s.state)
			ST_POR: begin
				if (por_qual) begin
					n.armed = 1'b1;
				end
				if (s.armed && !por_low) begin
					n.straps = s.lvl[STRAP_W-1:0]; // R5 R11 R14
					n.host = s.lvl[IN_HOST_BIT];
					n.armed = 1'b0;
					n.tcnt = '0;
					n.state = ST_HRST_DRIVE;
				end
			end
			ST_HRST_DRIVE: begin
				if (tk.sync_tick) begin
					n.tcnt = rsq_sat_inc(s.tcnt);
				end
				if (s.tcnt > HRST_OUT_TICKS && s.gap > NEG_GAP_TICKS) begin
					n.hr_oe = 1'b0; // R4 R13
					n.gap = '0;
					n.state = ST_HRST_WAIT;
				end
			end
			ST_HRST_WAIT: begin
				// Straps may still be sampled by others until the pin rises
				if (!hr_low) begin // R6
					n.tcnt = '0;
					n.state = ST_FUNC_WAIT;
				end
			end
			ST_FUNC_WAIT: begin
				if (tk.sync_tick) begin
					n.tcnt = rsq_sat_inc(s.tcnt);
				end
				if (s.tcnt > FUNC_DELAY_TICKS) begin
					n.strap_oe = 1'b1; // R8
					n.lock = '0;
					n.state = ST_PLL_WAIT;
				end
			end
			ST_PLL_WAIT: begin
				if (s.lock < LOCK_TARGET) begin
					n.lock = s.lock + 16'h0001;
				end else if (s.lvl[IN_PLL_BIT]) begin
					n.sysrst_n = 1'b1; // R9
					n.state = ST_RUN;
				end else begin
					n.timeout = 1'b1;
				end
			end
			ST_RUN: begin
				n.sysrst_n = 1'b1;
			end
			default: begin
				n.state = ST_POR;
			end
		endcase

		// Register write: accept address and data in either order
		if (S_AXI_AWVALID && s.awrdy) begin
			n.aw_hold = 1'b1;
			n.awaddr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && s.wrdy) begin
			n.w_hold = 1'b1;
			n.wdata = S_AXI_WDATA;
			n.wstrb = S_AXI_WSTRB;
		end
		if (s.bvalid && S_AXI_BREADY) begin
			n.bvalid = 1'b0;
		end
		if (s.aw_hold && s.w_hold && !s.bvalid) begin
			n.aw_hold = 1'b0;
			n.w_hold = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			if (s.awaddr == ADDR_CTRL) begin
				if (s.wstrb[0] && s.wdata[CTRL_TOCLR_BIT] && !(n.timeout && !s.timeout)) begin
					n.timeout = 1'b0;
				end
				if (s.wstrb[0] && s.wdata[CTRL_SWRST_BIT] && s.state inside {ST_FUNC_WAIT,
					ST_PLL_WAIT, ST_RUN}) begin
					n.state = ST_HRST_DRIVE;
					n.tcnt = '0;
				end
				if (s.wstrb[1]) begin
					n.func_out = s.wdata[CTRL_FUNC_LSB +: STRAP_W];
				end
			end else if (s.awaddr != ADDR_STATUS) begin
				n.bresp = RESP_SLVERR;
			end
		end
		n.awrdy = !n.aw_hold && !n.bvalid;
		n.wrdy = !n.w_hold && !n.bvalid;

		// Register read
		if (s.rvalid && S_AXI_RREADY) begin
			n.rvalid = 1'b0;
			n.arrdy = 1'b1;
		end
		if (S_AXI_ARVALID && s.arrdy) begin
			n.arrdy = 1'b0;
			n.rvalid = 1'b1;
			n.rdata = '0;
			n.rresp = RESP_OKAY;
			case (S_AXI_ARADDR)
				ADDR_CTRL: begin
					n.rdata[CTRL_FUNC_LSB +: STRAP_W] = s.func_out;
				end
				ADDR_STATUS: begin
					n.rdata[STS_STATE_LSB +: STS_STATE_W] = s.state;
					n.rdata[STS_LOCK_BIT] = s.lvl[IN_PLL_BIT];
					n.rdata[STS_TIMEOUT_BIT] = s.timeout;
					n.rdata[STS_HOST_BIT] = s.host;
					n.rdata[STS_SYSRST_BIT] = s.sysrst_n;
					n.rdata[STS_STRAP_LSB +: STRAP_W] = s.straps;
				end
				default: begin
					n.rresp = RESP_SLVERR;
				end
			endcase
		end

		// Outside hard reset or a software request restarts the drive phase
		if (hr_qual && s.state inside {ST_FUNC_WAIT, ST_PLL_WAIT, ST_RUN}) begin // R1
			n.state = ST_HRST_DRIVE;
			n.tcnt = '0;
		end
		if (n.state == ST_HRST_DRIVE && s.state != ST_HRST_DRIVE) begin
			n.hr_oe = 1'b1;
			n.strap_oe = 1'b0; // R7
			n.sysrst_n = 1'b0;
		end
		// Power-on reset overrides every state and pin-drive change above
		if (por_qual) begin
			n.state = ST_POR;
			n.armed = 1'b1;
			n.hr_oe = 1'b1;
			n.strap_oe = 1'b0; // R7
			n.sysrst_n = 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			s <= MAIN_RST;
		end else begin
			s <= n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign HARD_RESET_N_O = s.hr_o;
	assign HARD_RESET_N_OE = s.hr_oe;
	assign CFG_STRAP_O = s.func_out;
	assign CFG_STRAP_OE = {STRAP_W{s.strap_oe}};
	assign SYSTEM_RESET_N = s.sysrst_n;
	assign S_AXI_AWREADY = s.awrdy;
	assign S_AXI_WREADY = s.wrdy;
	assign S_AXI_BVALID = s.bvalid;
	assign S_AXI_BRESP = s.bresp;
	assign S_AXI_ARREADY = s.arrdy;
	assign S_AXI_RVALID = s.rvalid;
	assign S_AXI_RDATA = s.rdata;
	assign S_AXI_RRESP = s.rresp;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_release;
		$fell(s.hr_oe);
	endsequence

	sequence s_func_start;
		$rose(s.strap_oe);
	endsequence

	property p_hr_len;
		@(posedge CLK) disable iff (!RESETN)
		s_release |-> $past(s.tcnt) > HRST_OUT_TICKS;
	endproperty
	a_hr_len: assert property (p_hr_len) else $error("hard reset output too short"); // R4

	property p_hr_gap;
		@(posedge CLK) disable iff (!RESETN)
		s_release |-> $past(s.gap) > NEG_GAP_TICKS && s.gap == '0;
	endproperty
	a_hr_gap: assert property (p_hr_gap) else $error("negation gap too short"); // R4

	property p_strap_off;
		@(posedge CLK) disable iff (!RESETN)
		$rose(s.hr_oe) |-> !s.strap_oe && !s.sysrst_n;
	endproperty
	a_strap_off: assert property (p_strap_off) else $error("strap pins driven in reset"); // R7

	property p_func_delay;
		@(posedge CLK) disable iff (!RESETN)
		s_func_start |-> $past(s.state) == ST_FUNC_WAIT && $past(s.tcnt) > FUNC_DELAY_TICKS;
	endproperty
	a_func_delay: assert property (p_func_delay) else $error("outputs driven too soon"); // R8

	property p_lock_wait;
		@(posedge CLK) disable iff (!RESETN)
		$rose(s.sysrst_n) |-> $past(s.lock) >= LOCK_TARGET && $past(s.lvl[IN_PLL_BIT]);
	endproperty
	a_lock_wait: assert property (p_lock_wait) else $error("released before lock time"); // R9

	property p_strap_keep;
		@(posedge CLK) disable iff (!RESETN)
		($past(s.state) != ST_POR && s.state != ST_POR) |-> $stable(s.straps);
	endproperty
	a_strap_keep: assert property (p_strap_keep) else $error("straps changed"); // R14

	property p_open_drain;
		@(posedge CLK) disable iff (!RESETN)
		s.hr_oe |-> s.state inside {ST_POR, ST_HRST_DRIVE} && !s.hr_o;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("hard reset pin misdriven"); // R13

	property p_por_entry;
		@(posedge CLK) disable iff (!RESETN)
		por_qual |=> s.state == ST_POR && s.hr_oe && !s.strap_oe;
	endproperty
	a_por_entry: assert property (p_por_entry) else $error("power-on reset not obeyed"); // R2 R3

	property p_wr_resp;
		@(posedge CLK) disable iff (!RESETN)
		(s.aw_hold && s.w_hold && !s.bvalid) |=> s.bvalid && !s.aw_hold && !s.w_hold;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write response missing");

endmodule

// File: rsq_tick_if.sv
// Reference clock tick bundle between the tick generator and the sequencer
`timescale 1ns/1ps
interface rsq_tick_if;
	logic prim_tick;
	logic sync_tick;
	logic ref_tick;
	modport src (output prim_tick, output sync_tick, output ref_tick);
	modport dst (input prim_tick, input sync_tick, input ref_tick);
endinterface

// File: rsq_ticker.sv
// Samples the two reference clock pins and turns their rising edges into ticks
`timescale 1ns/1ps
module rsq_ticker
	import rsq_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic prim_pin,
	input wire logic sync_pin,
	input wire logic host_mode,
	input wire logic div_strap,
	rsq_tick_if.src tk
);

	typedef struct packed {
		logic [2:0] psy;
		logic [2:0] ssy;
		logic plvl;
		logic slvl;
		logic ph;
		logic prim;
		logic sync;
		logic ref_t;
	} rsq_tick_st_t;

	rsq_tick_st_t s;
	rsq_tick_st_t n;

	always_comb begin
		n = s;
		n.psy = {s.psy[1:0], prim_pin};
		n.ssy = {s.ssy[1:0], sync_pin};
		n.plvl = rsq_filt(s.plvl, s.psy[1], s.psy[2]);
		n.slvl = rsq_filt(s.slvl, s.ssy[1], s.ssy[2]);
		n.prim = n.plvl & ~s.plvl;
		if (n.prim) begin
			n.ph = ~s.ph;
		end
		// Host mode: sync period derived from primary clock by the divider strap
		n.sync = host_mode ? (n.prim & (~div_strap | s.ph)) : (n.slvl & ~s.slvl); // R10
		n.ref_t = host_mode ? n.prim : n.sync; // R12
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign tk.prim_tick = s.prim;
	assign tk.sync_tick = s.sync;
	assign tk.ref_tick = s.ref_t;

	property p_host_sync;
		@(posedge clk) disable iff (!rstn)
		($past(host_mode) && s.sync) |-> s.prim;
	endproperty
	a_host_sync: assert property (p_host_sync) else $error("sync tick without primary tick"); // R10

endmodule

// File: tb_top.sv
// Self-checking bench: board model, AXI4-Lite master and reference of the status word
`timescale 1ns/1ps
module tb_top;
	import rsq_pkg::*;
	localparam int PLL_CYC = 50;
	logic clk = 1'h0;
	logic resetn = 1'h0;
	logic pll_locked = 1'h0;
	logic por_n, hrst_wire, prim_clk, sync_clk, host, hrst_o, hrst_oe, sys_rst_n;
	logic [STRAP_W-1:0] strap_wire, strap_o, strap_oe;
	logic [AW-1:0] awaddr = '0;
	logic [AW-1:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = '0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int fail_count = 0;
	int comparisons = 0;

	always #2 clk = ~clk;

	rsq_reset_init_sequencer #(.PLL_LOCK_CYCLES(PLL_CYC)) u_rsq_reset_init_sequencer (
		.CLK(clk), .RESETN(resetn), .POWER_ON_RESET_N(por_n), .HARD_RESET_N_I(hrst_wire),
		.HARD_RESET_N_O(hrst_o), .HARD_RESET_N_OE(hrst_oe), .PRIMARY_CLOCK_IN(prim_clk),
		.PCI_SYNC_CLOCK_IN(sync_clk), .PCI_HOST_MODE(host), .PLL_LOCKED(pll_locked),
		.CFG_STRAP_I(strap_wire), .CFG_STRAP_O(strap_o), .CFG_STRAP_OE(strap_oe),
		.SYSTEM_RESET_N(sys_rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
	);
	rsq_board_model u_rsq_board_model (
		.clk(clk), .hrst_oe(hrst_oe), .strap_o(strap_o), .strap_oe(strap_oe), .por_n(por_n),
		.hrst_wire(hrst_wire), .prim_clk(prim_clk), .sync_clk(sync_clk), .host(host),
		.strap_wire(strap_wire)
	);

	// ----------------------------------------------------------------
	// Checking helpers
	// ----------------------------------------------------------------
	task automatic complete_run();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [31:0] exp_status(input int st, input logic lk, input logic to,
		input logic h, input logic sr, input logic [STRAP_W-1:0] s);
		return {18'h0, s, sr, h, to, lk, 1'h0, st[2:0]};
	endfunction
	function automatic logic probe(input int sel);
		case (sel)
			0: return hrst_oe;
			1: return &strap_oe;
			default: return sys_rst_n;
		endcase
	endfunction
	task automatic wait_for(input int sel, input logic v, input int lim, output int n);
		n = 0;
		while (probe(sel) !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		check("wait bound", 1, n < lim);
	endtask

	// ----------------------------------------------------------------
	// AXI4-Lite master
	// ----------------------------------------------------------------
	task automatic axi_write(input logic [AW-1:0] a, input logic [31:0] d, input logic [3:0] st,
		output logic [1:0] r);
		int n;
		logic aw_ok;
		logic w_ok;
		n = 0;
		aw_ok = 1'h0;
		w_ok = 1'h0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= st;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (n < 100) begin
			@(posedge clk);
			n++;
			if (bvalid === 1'h1) begin
				r = bresp;
				bready <= 1'h0;
				break;
			end
			if (!aw_ok && awready === 1'h1) begin
				aw_ok = 1'h1;
				awvalid <= 1'h0;
			end
			if (!w_ok && wready === 1'h1) begin
				w_ok = 1'h1;
				wvalid <= 1'h0;
			end
		end
		check("write answered", 1, n < 100);
	endtask
	task automatic axi_read(input logic [AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		while (n < 100) begin
			@(posedge clk);
			n++;
			if (rvalid === 1'h1) begin
				d = rdata;
				r = rresp;
				rready <= 1'h0;
				break;
			end
			if (arready === 1'h1) begin
				arvalid <= 1'h0;
			end
		end
		check("read answered", 1, n < 100);
	endtask

	// ----------------------------------------------------------------
	// Power-on sequence and its expected status
	// ----------------------------------------------------------------
	task automatic boot(input logic h, input logic [STRAP_W-1:0] s, input int ts, input logic lk);
		int n;
		time t0;
		logic [1:0] r;
		logic [31:0] d;
		u_rsq_board_model.power_on(40, h, s);
		wait_for(0, 1'h0, 30000, n);
		check("hard_reset_n width", 1, n * 4 >= 512 * ts);
		wait_for(1, 1'h1, 300, n);
		check("strap drive delay", 1, n * 4 >= ts);
		t0 = $time;
		u_rsq_board_model.retarget(~s);
		axi_read(ADDR_STATUS, d, r);
		check("status pll wait", exp_status(4, lk, 0, h, 0, s), d);
		if (!lk) begin
			repeat (PLL_CYC + 20) @(posedge clk);
			axi_read(ADDR_STATUS, d, r);
			check("status timeout", exp_status(4, 0, 1, h, 0, s), d);
			pll_locked <= 1'h1;
		end
		wait_for(2, 1'h1, PLL_CYC + 40, n);
		check("lock wait", 1, ($time - t0) / 4 >= PLL_CYC);
		axi_read(ADDR_STATUS, d, r);
		check("status run", exp_status(5, 1, !lk, h, 1, s), d);
		if (!lk) begin
			axi_write(ADDR_CTRL, 32'h0000_0002, 4'hf, r);
			axi_read(ADDR_STATUS, d, r);
			check("timeout clear", exp_status(5, 1, 0, h, 1, s), d);
		end
	endtask

	always @(posedge clk) begin
		if (resetn === 1'h1 && hrst_oe === 1'h1 && strap_oe !== '0) begin
			fail_count++;
			$display("CHECK FAILED strap release expected 00 seen %h", strap_oe);
		end
	end

	initial begin
		#300000;
		fail_count++;
		complete_run();
	end

	initial begin
		int n;
		logic h;
		logic lk;
		logic [1:0] r;
		logic [31:0] d;
		logic [31:0] rd;
		logic [STRAP_W-1:0] s;
		n = $urandom(62368);
		repeat (4) @(posedge clk);
		check("oe in reset", 1, hrst_oe);
		check("drive in reset", 0, hrst_o);
		check("strap oe in reset", 0, strap_oe);
		check("sysrst in reset", 0, sys_rst_n);
		for (int i = 0; i < 3; i++) begin
			h = (i < 2);
			lk = (i != 0);
			s = $urandom;
			s[DIV_BIT] = (i == 1);
			resetn <= 1'h0;
			pll_locked <= lk;
			repeat (4) @(posedge clk);
			resetn <= 1'h1;
			boot(h, s, h ? 20 * (i + 1) : 30, lk);
		end
		d = $urandom & 32'h0000_3f00;
		axi_write(ADDR_CTRL, d, 4'hf, r);
		check("ctrl resp", RESP_OKAY, r);
		axi_write(ADDR_CTRL, d ^ 32'h0000_3f00, 4'h1, r);
		axi_read(ADDR_CTRL, rd, r);
		check("ctrl field", d[13:8], rd[13:8]);
		check("func pins", d[13:8], strap_wire);
		check("func drive", 6'h3f, strap_oe);
		axi_write(12'h010, 32'hffff_ffff, 4'hf, r);
		check("unmapped write", RESP_SLVERR, r);
		axi_read(12'h010, rd, r);
		check("unmapped read", RESP_SLVERR, r);
		check("unmapped data", 0, rd);
		axi_write(ADDR_STATUS, 32'h0000_0000, 4'hf, r);
		check("status write", RESP_OKAY, r);
		u_rsq_board_model.hard_reset(8);
		repeat (20) @(posedge clk);
		axi_read(ADDR_STATUS, rd, r);
		check("short hard_reset_n", exp_status(5, 1, 0, 0, 1, s), rd);
		u_rsq_board_model.hard_reset(80);
		check("ext oe", 1, hrst_oe);
		check("ext strap off", 0, strap_oe);
		check("ext sysrst", 0, sys_rst_n);
		wait_for(2, 1'h1, 30000, n);
		axi_write(ADDR_CTRL, 32'h0000_0001, 4'hf, r);
		wait_for(0, 1'h1, 20, n);
		check("sw strap off", 0, strap_oe);
		wait_for(0, 1'h0, 30000, n);
		check("sw hard_reset_n width", 1, n * 4 >= 512 * 30);
		wait_for(2, 1'h1, 30000, n);
		axi_read(ADDR_STATUS, rd, r);
		check("status kept", exp_status(5, 1, 0, 0, 1, s), rd);
		complete_run();
	end
endmodule
